// *** hw/svmadc_pkg.sv ***
// constants for the supply voltage monitor converter control
package svmadc_pkg;
  // register byte offsets
  localparam logic [7:0] SVMADC_OFF_CTRL      = 8'h00;
  localparam logic [7:0] SVMADC_OFF_CHAN      = 8'h04;
  localparam logic [7:0] SVMADC_OFF_THRESH    = 8'h08;
  localparam logic [7:0] SVMADC_OFF_RESULT    = 8'h0c;
  localparam logic [7:0] SVMADC_OFF_IRQ_STAT  = 8'h10;
  localparam logic [7:0] SVMADC_OFF_IRQ_EN    = 8'h14;
  localparam logic [7:0] SVMADC_OFF_IRQ_CLR   = 8'h18;
  // control register field positions
  localparam int SVMADC_CTRL_RUN      = 0;
  localparam int SVMADC_CTRL_CMP_EN   = 1;
  localparam int SVMADC_CTRL_REF_LO   = 2;
  localparam int SVMADC_CTRL_REF_HI   = 3;
  localparam int SVMADC_CTRL_TRIG_LO  = 4;
  localparam int SVMADC_CTRL_TRIG_HI  = 5;
  localparam int SVMADC_CTRL_SCAN     = 6;
  localparam int SVMADC_CTRL_ONESHOT  = 7;
  localparam int SVMADC_CTRL_IT_RUN   = 8;
  localparam int SVMADC_CTRL_LAMP_EN  = 9;
  localparam int SVMADC_CTRL_TMODE_LO = 10;
  localparam int SVMADC_CTRL_TMODE_HI = 11;
  // interrupt status field positions
  localparam int SVMADC_IRQ_CONV_END  = 0;
  localparam int SVMADC_IRQ_MISSED    = 1;
  localparam int SVMADC_IRQ_W         = 2;
  // codes
  localparam logic [1:0] SVMADC_REF_VDD       = 2'h0;
  localparam logic [1:0] SVMADC_REF_INTERNAL  = 2'h2;
  localparam logic [1:0] SVMADC_REF_PROHIBIT  = 2'h3;
  localparam logic [1:0] SVMADC_TRIG_TM01     = 2'h0;
  localparam logic [1:0] SVMADC_TRIG_ELC      = 2'h1;
  localparam logic [1:0] SVMADC_TRIG_RTC      = 2'h2;
  localparam logic [1:0] SVMADC_TRIG_INTERVAL = 2'h3;
  localparam logic [1:0] SVMADC_TMODE_HW_WAIT = 2'h3;
  localparam logic [4:0] SVMADC_CHAN_ZERO     = 5'h00;
  // reset values
  localparam logic [1:0] SVMADC_RST_REF       = SVMADC_REF_VDD;
  localparam logic [1:0] SVMADC_RST_TRIG      = SVMADC_TRIG_INTERVAL;
  localparam logic [4:0] SVMADC_RST_CHAN      = SVMADC_CHAN_ZERO;
  localparam logic [7:0] SVMADC_RST_THRESH    = 8'h5f;
  localparam logic [7:0] SVMADC_RST_RESULT    = 8'h00;
  // timing
  localparam int SVMADC_CLK_PERIOD_NS   = 10;
  localparam int SVMADC_STAB_TIME_NS    = 5000;
  localparam int SVMADC_STAB_CYCLES     =
    (SVMADC_STAB_TIME_NS + SVMADC_CLK_PERIOD_NS - 1) / SVMADC_CLK_PERIOD_NS;
  localparam int SVMADC_CONV_TIME_NS    = 2000;
  localparam int SVMADC_CONV_CYCLES     =
    (SVMADC_CONV_TIME_NS + SVMADC_CLK_PERIOD_NS - 1) / SVMADC_CLK_PERIOD_NS;
  localparam int SVMADC_TICK_TIME_US    = 100;
  localparam int SVMADC_TICK_CYCLES     =
    SVMADC_TICK_TIME_US * 1000 / SVMADC_CLK_PERIOD_NS;
  localparam int SVMADC_IT_PRESCALE     = 4;
  localparam int SVMADC_LAMP_HALF_MS    = 250;
  localparam int SVMADC_LAMP_HALF_CYCLES =
    SVMADC_LAMP_HALF_MS * 1000000 / SVMADC_CLK_PERIOD_NS;
  // converter sequencer states
  typedef enum logic [1:0] {
    SVMADC_IDLE = 2'b00,
    SVMADC_STAB = 2'b01,
    SVMADC_CONV = 2'b10
  } svmadc_state_type;
endpackage

// *** hw/svmadc_top.sv ***
// supply voltage monitor converter control with apb registers
`timescale 1ns/1ps
module svmadc_top
  import svmadc_pkg::*;
#(
  parameter int STAB_CYCLES      = svmadc_pkg::SVMADC_STAB_CYCLES,
  parameter int CONV_CYCLES      = svmadc_pkg::SVMADC_CONV_CYCLES,
  parameter int TICK_CYCLES      = svmadc_pkg::SVMADC_TICK_CYCLES,
  parameter int LAMP_HALF_CYCLES = svmadc_pkg::SVMADC_LAMP_HALF_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  analog_channel_zero,
  input  wire logic        elc_event,
  input  wire logic        rtc_irq,
  output logic             sample_hold,
  output logic [1:0]       ref_select,
  output logic             interval_tick_irq,
  output logic             conversion_end_irq,
  output logic             indicator_lamp
);
  import svmadc_pkg::*;

  localparam int IT_COUNT = TICK_CYCLES / SVMADC_IT_PRESCALE;
  localparam int LAMP_W   = $clog2(LAMP_HALF_CYCLES + 1);

  if (IT_COUNT < 2 || IT_COUNT > 4096)
    $error("tick period does not fit the 12-bit interval counter");
  if (STAB_CYCLES < 1 || STAB_CYCLES > 65535 ||
      CONV_CYCLES < 1 || CONV_CYCLES > 65535)
    $error("converter timing outside the 16-bit sequencer counter");
  if (LAMP_HALF_CYCLES < 2)
    $error("lamp half period too short");

  localparam logic [15:0] STAB_LOAD = 16'(STAB_CYCLES - 1);
  localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES - 1);
  localparam logic [11:0] IT_LOAD   = 12'(IT_COUNT - 1);
  localparam logic [1:0]  PRE_LOAD  = 2'(SVMADC_IT_PRESCALE - 1);
  localparam logic [LAMP_W-1:0] LAMP_LOAD = LAMP_W'(LAMP_HALF_CYCLES - 1);

  function automatic logic pick_trigger(input logic [1:0] sel,
                                        input logic       tm01,
                                        input logic       elc,
                                        input logic       rtc,
                                        input logic       tick);
    logic hit;
    hit = 1'b0;
    case (sel)
      SVMADC_TRIG_TM01:     hit = tm01;
      SVMADC_TRIG_ELC:      hit = elc;
      SVMADC_TRIG_RTC:      hit = rtc;
      SVMADC_TRIG_INTERVAL: hit = tick;
      default:              hit = 1'b0;
    endcase
    return hit;
  endfunction

  // register state
  logic                  run_bit;
  logic                  cmp_en_bit;
  logic [1:0]            ref_sel;
  logic [1:0]            trig_sel;
  logic                  it_run;
  logic                  lamp_en;
  logic [4:0]            chan_sel;
  logic [7:0]            threshold;
  logic [SVMADC_IRQ_W-1:0] irq_status;
  logic [SVMADC_IRQ_W-1:0] irq_enable;
  logic [31:0]           rd_data;
  logic                  rd_err;
  logic                  next_run_bit;
  logic                  next_cmp_en_bit;
  logic [1:0]            next_ref_sel;
  logic [1:0]            next_trig_sel;
  logic                  next_it_run;
  logic                  next_lamp_en;
  logic [4:0]            next_chan_sel;
  logic [7:0]            next_threshold;
  logic [SVMADC_IRQ_W-1:0] next_irq_status;
  logic [SVMADC_IRQ_W-1:0] next_irq_enable;
  logic [31:0]           next_rd_data;
  logic                  next_rd_err;
  // sequencer state
  svmadc_state_type      state;
  svmadc_state_type      next_state;
  logic [15:0]           seq_cnt;
  logic [15:0]           next_seq_cnt;
  logic [7:0]            result;
  logic [7:0]            next_result;
  logic                  next_sample_hold;
  logic                  conv_done;
  logic                  low_hit;
  logic                  trig_missed;
  // interval timer and lamp timer
  logic [1:0]            pre_cnt;
  logic [11:0]           it_cnt;
  logic                  tick;
  logic [1:0]            next_pre_cnt;
  logic [11:0]           next_it_cnt;
  logic                  next_tick;
  logic                  lamp_active;
  logic [LAMP_W-1:0]     lamp_cnt;
  logic                  lamp_out;
  logic                  tm01_evt;
  logic                  next_lamp_active;
  logic [LAMP_W-1:0]     next_lamp_cnt;
  logic                  next_lamp_out;
  logic                  next_tm01_evt;

  logic wr_acc;
  logic rd_setup;
  logic trig;
  logic [31:0] ctrl_word;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready   = 1'b1;
  assign prdata   = rd_data;
  assign pslverr  = rd_err;
  assign trig = pick_trigger(trig_sel, tm01_evt, elc_event, rtc_irq, tick);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[SVMADC_CTRL_RUN]    = run_bit;
    ctrl_word[SVMADC_CTRL_CMP_EN] = cmp_en_bit;
    ctrl_word[SVMADC_CTRL_REF_HI:SVMADC_CTRL_REF_LO]   = ref_sel;
    ctrl_word[SVMADC_CTRL_TRIG_HI:SVMADC_CTRL_TRIG_LO] = trig_sel;
    ctrl_word[SVMADC_CTRL_SCAN]    = 1'b0;
    ctrl_word[SVMADC_CTRL_ONESHOT] = 1'b1;
    ctrl_word[SVMADC_CTRL_IT_RUN]  = it_run;
    ctrl_word[SVMADC_CTRL_LAMP_EN] = lamp_en;
    ctrl_word[SVMADC_CTRL_TMODE_HI:SVMADC_CTRL_TMODE_LO] =
      SVMADC_TMODE_HW_WAIT;
  end

  // register file next values
  always_comb begin
    next_run_bit    = run_bit;
    next_cmp_en_bit = cmp_en_bit;
    next_ref_sel    = ref_sel;
    next_trig_sel   = trig_sel;
    next_it_run     = it_run;
    next_lamp_en    = lamp_en;
    next_chan_sel   = chan_sel;
    next_threshold  = threshold;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_rd_data    = rd_data;
    next_rd_err     = 1'b0;
    if (wr_acc && paddr == SVMADC_OFF_CTRL) begin
      if (pstrb[0]) begin
        next_run_bit    = pwdata[SVMADC_CTRL_RUN];
        next_cmp_en_bit = pwdata[SVMADC_CTRL_CMP_EN];
        next_trig_sel   = pwdata[SVMADC_CTRL_TRIG_HI:SVMADC_CTRL_TRIG_LO];
        if (!run_bit && !cmp_en_bit &&
            pwdata[SVMADC_CTRL_REF_HI:SVMADC_CTRL_REF_LO] !=
            SVMADC_REF_PROHIBIT) begin
          next_ref_sel = pwdata[SVMADC_CTRL_REF_HI:SVMADC_CTRL_REF_LO];
        end
      end
      if (pstrb[1]) begin
        next_it_run  = pwdata[SVMADC_CTRL_IT_RUN];
        next_lamp_en = pwdata[SVMADC_CTRL_LAMP_EN];
      end
    end else if (wr_acc && paddr == SVMADC_OFF_CHAN) begin
      if (pstrb[0]) begin
        next_chan_sel = pwdata[4:0];
      end
    end else if (wr_acc && paddr == SVMADC_OFF_THRESH) begin
      if (pstrb[0]) begin
        next_threshold = pwdata[7:0];
      end
    end else if (wr_acc && paddr == SVMADC_OFF_IRQ_EN) begin
      if (pstrb[0]) begin
        next_irq_enable = pwdata[SVMADC_IRQ_W-1:0];
      end
    end else if (wr_acc && paddr == SVMADC_OFF_IRQ_CLR) begin
      if (pstrb[0]) begin
        next_irq_status = irq_status & ~pwdata[SVMADC_IRQ_W-1:0];
      end
    end
    // set wins over a clear in the same cycle
    if (conv_done && low_hit) begin
      next_irq_status[SVMADC_IRQ_CONV_END] = 1'b1;
    end
    if (trig_missed) begin
      next_irq_status[SVMADC_IRQ_MISSED] = 1'b1;
    end
    if (rd_setup) begin
      next_rd_data = 32'h0000_0000;
      if (paddr == SVMADC_OFF_CTRL) begin
        next_rd_data = ctrl_word;
      end else if (paddr == SVMADC_OFF_CHAN) begin
        next_rd_data[4:0] = chan_sel;
      end else if (paddr == SVMADC_OFF_THRESH) begin
        next_rd_data[7:0] = threshold;
      end else if (paddr == SVMADC_OFF_RESULT) begin
        next_rd_data[7:0] = result;
      end else if (paddr == SVMADC_OFF_IRQ_STAT) begin
        next_rd_data[SVMADC_IRQ_W-1:0] = irq_status;
      end else if (paddr == SVMADC_OFF_IRQ_EN) begin
        next_rd_data[SVMADC_IRQ_W-1:0] = irq_enable;
      end else if (paddr == SVMADC_OFF_IRQ_CLR) begin
        next_rd_data = 32'h0000_0000;
      end else begin
        next_rd_err = 1'b1;
      end
    end else if (psel && penable) begin
      next_rd_err = rd_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_bit    <= 1'b0;
      cmp_en_bit <= 1'b0;
      ref_sel    <= SVMADC_RST_REF;
      trig_sel   <= SVMADC_RST_TRIG;
      it_run     <= 1'b0;
      lamp_en    <= 1'b0;
      chan_sel   <= SVMADC_RST_CHAN;
      threshold  <= SVMADC_RST_THRESH;
      irq_status <= '0;
      irq_enable <= '0;
      rd_data    <= 32'h0000_0000;
      rd_err     <= 1'b0;
    end else begin
      run_bit    <= next_run_bit;
      cmp_en_bit <= next_cmp_en_bit;
      ref_sel    <= next_ref_sel;
      trig_sel   <= next_trig_sel;
      it_run     <= next_it_run;
      lamp_en    <= next_lamp_en;
      chan_sel   <= next_chan_sel;
      threshold  <= next_threshold;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rd_data    <= next_rd_data;
      rd_err     <= next_rd_err;
    end
  end

  assign ref_select         = ref_sel;
  assign conversion_end_irq = |(irq_status & irq_enable);

  // conversion sequencer
  always_comb begin
    next_state       = state;
    next_seq_cnt     = seq_cnt;
    next_result      = result;
    next_sample_hold = 1'b0;
    conv_done        = 1'b0;
    trig_missed      = 1'b0;
    low_hit          = analog_channel_zero <= threshold;
    case (state)
      SVMADC_IDLE: begin
        if (trig && run_bit && cmp_en_bit &&
            chan_sel == SVMADC_CHAN_ZERO) begin
          next_state   = SVMADC_STAB;
          next_seq_cnt = STAB_LOAD;
        end
      end
      SVMADC_STAB: begin
        if (seq_cnt == 16'h0000) begin
          next_state       = SVMADC_CONV;
          next_seq_cnt     = CONV_LOAD;
          next_sample_hold = 1'b1;
        end else begin
          next_seq_cnt = seq_cnt - 16'h0001;
        end
      end
      SVMADC_CONV: begin
        next_sample_hold = 1'b1;
        if (seq_cnt == 16'h0000) begin
          next_state       = SVMADC_IDLE;
          next_sample_hold = 1'b0;
          next_result      = analog_channel_zero;
          conv_done        = 1'b1;
        end else begin
          next_seq_cnt = seq_cnt - 16'h0001;
        end
      end
      default: begin
        next_state = SVMADC_IDLE;
      end
    endcase
    if (state != SVMADC_IDLE && trig) begin
      trig_missed = 1'b1;
    end
    if (!run_bit || !cmp_en_bit) begin
      next_state       = SVMADC_IDLE;
      next_sample_hold = 1'b0;
      conv_done        = 1'b0;
      next_result      = result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= SVMADC_IDLE;
      seq_cnt     <= 16'h0000;
      result      <= SVMADC_RST_RESULT;
      sample_hold <= 1'b0;
    end else begin
      state       <= next_state;
      seq_cnt     <= next_seq_cnt;
      result      <= next_result;
      sample_hold <= next_sample_hold;
    end
  end

  // interval timer and lamp timer
  always_comb begin
    next_pre_cnt     = pre_cnt;
    next_it_cnt      = it_cnt;
    next_tick        = 1'b0;
    next_lamp_active = lamp_active;
    next_lamp_cnt    = lamp_cnt;
    next_lamp_out    = lamp_out;
    next_tm01_evt    = 1'b0;
    if (!it_run) begin
      next_pre_cnt = PRE_LOAD;
      next_it_cnt  = IT_LOAD;
    end else if (pre_cnt != 2'h0) begin
      next_pre_cnt = pre_cnt - 2'h1;
    end else begin
      next_pre_cnt = PRE_LOAD;
      if (it_cnt == 12'h000) begin
        next_it_cnt = IT_LOAD;
        next_tick   = 1'b1;
      end else begin
        next_it_cnt = it_cnt - 12'h001;
      end
    end
    if (conv_done && low_hit && lamp_en) begin
      next_lamp_active = 1'b1;
    end
    if (!lamp_en) begin
      next_lamp_active = 1'b0;
      next_lamp_cnt    = LAMP_LOAD;
      next_lamp_out    = 1'b0;
    end else if (lamp_active) begin
      if (lamp_cnt == '0) begin
        next_lamp_cnt = LAMP_LOAD;
        next_lamp_out = !lamp_out;
        next_tm01_evt = 1'b1;
      end else begin
        next_lamp_cnt = lamp_cnt - LAMP_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt     <= 2'h0;
      it_cnt      <= 12'h000;
      tick        <= 1'b0;
      lamp_active <= 1'b0;
      lamp_cnt    <= '0;
      lamp_out    <= 1'b0;
      tm01_evt    <= 1'b0;
    end else begin
      pre_cnt     <= next_pre_cnt;
      it_cnt      <= next_it_cnt;
      tick        <= next_tick;
      lamp_active <= next_lamp_active;
      lamp_cnt    <= next_lamp_cnt;
      lamp_out    <= next_lamp_out;
      tm01_evt    <= next_tm01_evt;
    end
  end

  assign interval_tick_irq = tick;
  assign indicator_lamp    = lamp_out;

endmodule // svmadc_top

// *** sim/svmadc_props.sv ***
// assertion checker for the supply monitor converter control
`timescale 1ns/1ps
module svmadc_props
  import svmadc_pkg::*;
#(
  parameter int STAB_CYCLES      = 500,
  parameter int CONV_CYCLES      = 200,
  parameter int TICK_CYCLES      = 10000,
  parameter int LAMP_HALF_CYCLES = 25000000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        sample_hold,
  input wire logic [1:0]  ref_select,
  input wire logic        interval_tick_irq,
  input wire logic        conversion_end_irq,
  input wire logic        indicator_lamp
);
  int   low_cnt;
  int   hold_cnt;
  int   tick_gap;
  int   lamp_gap;
  logic tick_seen;
  logic ctl_on;
  logic ctl_any;
  logic ctl_tick;
  int   wr_age;
  logic en_wr;
  logic ctl_wr;
  assign en_wr = psel && penable && pwrite && paddr == SVMADC_OFF_IRQ_EN;
  assign ctl_wr = psel && penable && pwrite && paddr == SVMADC_OFF_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt   <= 0;
      hold_cnt  <= 0;
      tick_gap  <= 0;
      lamp_gap  <= 0;
      tick_seen <= 1'b0;
      ctl_on    <= 1'b0;
      ctl_any   <= 1'b0;
      ctl_tick  <= 1'b1;
      wr_age    <= 0;
    end else begin
      low_cnt   <= sample_hold ? 0 : low_cnt + 1;
      hold_cnt  <= sample_hold ? hold_cnt + 1 : 0;
      tick_gap  <= interval_tick_irq ? 1 : tick_gap + 1;
      lamp_gap  <= $changed(indicator_lamp) ? 1 : lamp_gap + 1;
      tick_seen <= tick_seen | interval_tick_irq;
      if (ctl_wr && pstrb[0]) begin
        ctl_on   <= pwdata[0] & pwdata[1];
        ctl_any  <= pwdata[0] | pwdata[1];
        ctl_tick <= pwdata[5:4] == SVMADC_TRIG_INTERVAL;
        wr_age   <= 0;
      end else begin
        wr_age   <= wr_age + 1;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_err_unmapped: assert property (psel && penable &&
    paddr > SVMADC_OFF_IRQ_CLR |-> pslverr) else $error("no error response");
  chk_ref_legal: assert property (
    ref_select != SVMADC_REF_PROHIBIT) else $error("prohibited reference");
  chk_ref_stopped: assert property (
    $changed(ref_select) |-> !$past(ctl_any, 2)) else $error("ref moved");
  chk_tick_period: assert property (
    interval_tick_irq && tick_seen |-> tick_gap == TICK_CYCLES)
    else $error("tick spacing wrong");
  chk_stab_wait: assert property (
    $rose(sample_hold) |-> low_cnt >= STAB_CYCLES) else $error("short settle");
  chk_stab_from_tick: assert property (
    $rose(sample_hold) && ctl_tick && wr_age > STAB_CYCLES + 1 |->
    tick_gap == STAB_CYCLES + 1) else $error("settle not counted");
  chk_hold_len: assert property (
    $fell(sample_hold) && ctl_on |->
    hold_cnt inside {[CONV_CYCLES - 1 : CONV_CYCLES + 1]})
    else $error("conversion length wrong");
  chk_start_enabled: assert property (
    $rose(sample_hold) |-> ctl_on) else $error("start while disabled");
  chk_irq_cause: assert property (
    $rose(conversion_end_irq) |-> $past(sample_hold) ||
    $past(sample_hold, 2) || $past(en_wr) || $past(en_wr, 2))
    else $error("interrupt without cause");
  chk_lamp_gap: assert property (
    $rose(indicator_lamp) |-> lamp_gap >= LAMP_HALF_CYCLES - 1)
    else $error("lamp toggles early");
endmodule // svmadc_props

bind svmadc_top svmadc_props #(.STAB_CYCLES(STAB_CYCLES),
  .CONV_CYCLES(CONV_CYCLES), .TICK_CYCLES(TICK_CYCLES),
  .LAMP_HALF_CYCLES(LAMP_HALF_CYCLES)) i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .sample_hold(sample_hold), .ref_select(ref_select),
  .interval_tick_irq(interval_tick_irq),
  .conversion_end_irq(conversion_end_irq), .indicator_lamp(indicator_lamp));

// *** sim/svmadc_supply_model.sv ***
// far side model: divided supply level and foreign trigger pulses
`timescale 1ns/1ps
module svmadc_supply_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] level,
  output logic      [7:0] analog_channel_zero,
  output logic            elc_event,
  output logic            rtc_irq
);
  logic [4:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt                 <= 5'h00;
      analog_channel_zero <= 8'h00;
      elc_event           <= 1'b0;
      rtc_irq             <= 1'b0;
    end else begin
      cnt                 <= cnt + 5'h01;
      analog_channel_zero <= level; // channel zero only
      elc_event           <= (cnt == 5'h07); // ELC and RTC trigger sources
      rtc_irq             <= (cnt == 5'h13);
    end
  end
endmodule // svmadc_supply_model

// *** sim/tb.sv ***
// self-checking bench for the supply monitor converter control
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb;
  import svmadc_pkg::*;
  localparam int LAMP = 16;
  localparam logic [7:0] CORNER [4] = '{8'h5f, 8'h60, 8'h00, 8'hff};
  localparam logic [31:0] TRIG_CTRL [3] = '{32'h31b, 32'h32b, 32'h30b};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  level;
  logic [7:0]  analog_channel_zero;
  logic        elc_event;
  logic        rtc_irq;
  logic        sample_hold;
  logic [1:0]  ref_select;
  logic        interval_tick_irq;
  logic        conversion_end_irq;
  logic        indicator_lamp;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [7:0]  v;
  logic        err;
  logic [7:0]  log_q[$];
  int          bad_count;
  int          tests_run;
  int          cyc;
  int          n;
  svmadc_top #(.STAB_CYCLES(8), .CONV_CYCLES(4), .TICK_CYCLES(40),
    .LAMP_HALF_CYCLES(LAMP)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_channel_zero(analog_channel_zero),
    .elc_event(elc_event), .rtc_irq(rtc_irq), .sample_hold(sample_hold),
    .ref_select(ref_select), .interval_tick_irq(interval_tick_irq),
    .conversion_end_irq(conversion_end_irq),
    .indicator_lamp(indicator_lamp));
  svmadc_supply_model i_far (.pclk(pclk), .presetn(presetn), .level(level),
    .analog_channel_zero(analog_channel_zero), .elc_event(elc_event),
    .rtc_irq(rtc_irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic is_low(input logic [7:0] x);
    return x <= SVMADC_RST_THRESH;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pstrb, level, bad_count, tests_run, cyc} = '0;
    pstrb = 4'hf;
    seed = 32'h4bb8;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SVMADC_OFF_THRESH, 0);
    `CHK(rd, 32'h5f)
    apb(0, SVMADC_OFF_RESULT, 0);
    `CHK(rd, 32'h0)
    apb(0, SVMADC_OFF_CTRL, 0);
    `CHK(rd[5:4], SVMADC_TRIG_INTERVAL)
    `CHK(rd[7:6], 2'b10)
    `CHK(rd[11:10], SVMADC_TMODE_HW_WAIT)
    apb(0, 8'h1c, 0);
    `CHK({err, rd}, 33'h100000000)
    `CHK(pready, 1'b1)
    apb(1, SVMADC_OFF_CTRL, 32'h3c);
    settle;
    `CHK(ref_select, SVMADC_REF_VDD)
    apb(1, SVMADC_OFF_CTRL, 32'h38); // stopped while choosing
    settle;
    `CHK(ref_select, SVMADC_REF_INTERNAL)
    repeat (SVMADC_STAB_CYCLES) @(posedge pclk);
    apb(1, SVMADC_OFF_CHAN, 0);
    apb(1, SVMADC_OFF_IRQ_EN, 1);
    apb(1, SVMADC_OFF_CTRL, 32'h33b);
    apb(1, SVMADC_OFF_CTRL, 32'h333);
    settle;
    `CHK(ref_select, SVMADC_REF_INTERNAL)
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = (i < 4) ? CORNER[i] : seed[7:0];
      level <= v;
      while (sample_hold !== 1'b1) @(posedge pclk);
      while (sample_hold !== 1'b0) @(posedge pclk);
      settle;
      apb(0, SVMADC_OFF_RESULT, 0);
      `CHK(rd, {24'h0, v})
      apb(0, SVMADC_OFF_IRQ_STAT, 0);
      `CHK(rd[0], is_low(v))
      `CHK(conversion_end_irq, is_low(v))
      if (rd[0] === 1'b1) log_q.push_back(v);
      apb(1, SVMADC_OFF_IRQ_EN, 0);
      settle;
      `CHK(conversion_end_irq, 1'b0)
      apb(1, SVMADC_OFF_IRQ_EN, 1);
      apb(1, SVMADC_OFF_IRQ_CLR, 3);
      settle;
      `CHK(conversion_end_irq, 1'b0)
    end
    `CHK(log_q[0], 8'h5f)
    n = 0;
    while (indicator_lamp !== 1'b1 && n < 4 * LAMP) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (indicator_lamp !== 1'b0 && n < 4 * LAMP) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n, LAMP)
    apb(1, SVMADC_OFF_CTRL, 32'h339);
    settle;
    n = 0;
    repeat (120) begin
      @(posedge pclk);
      if (sample_hold !== 1'b0) n++;
    end
    `CHK(n, 0)
    foreach (TRIG_CTRL[k]) begin
      level <= 8'ha0 + 8'(k);
      apb(1, SVMADC_OFF_CTRL, TRIG_CTRL[k]);
      while (sample_hold !== 1'b1) @(posedge pclk);
      while (sample_hold !== 1'b0) @(posedge pclk);
      settle;
      apb(0, SVMADC_OFF_RESULT, 0);
      `CHK(rd, {24'h0, 8'ha0 + 8'(k)})
    end
    report_and_stop;
  end
endmodule // tb
